/* File: verilog/cspc_regs.svh */
/*
 Constants for the configuration status pin controller: state timing,
 pin counts and reset values.
 Assumes CLK_I runs at 40 MHz and that includers see these macros once.
*/
`ifndef CSPC_REGS_SVH
`define CSPC_REGS_SVH

`define CSPC_NUM_IO        8
`define CSPC_NUM_GCK       8
`define CSPC_CLK_MHZ       40
`define CSPC_WAIT_MIN_US   30
`define CSPC_WAIT_MAX_US   300
// least time as a plain product, no rounding: 30 us at 40 MHz
`define CSPC_WAIT_CYC      ((`CSPC_WAIT_MIN_US * `CSPC_CLK_MHZ))
`define CSPC_CLEAR_CYC     16'h0040
`define CSPC_CNT_W         16
`define CSPC_CNT_RST       16'h0000

`endif

/* File: verilog/cspc_pkg.sv */
/*
 Types for the configuration status pin controller.
 Assumes cspc_regs.svh supplies the widths.
*/
`include "cspc_regs.svh"
package cspc_pkg;
   // gray along clear -> wait -> hold -> load -> user
   typedef enum logic [2:0] {
      CSPC_CLEAR = 3'h0,
      CSPC_WAIT  = 3'h1,
      CSPC_HOLD  = 3'h3,
      CSPC_LOAD  = 3'h2,
      CSPC_USER  = 3'h6
   } cspc_state_t;

   typedef struct packed {
      logic [`CSPC_NUM_IO-1:0] out;
      logic [`CSPC_NUM_IO-1:0] oe;
      logic [`CSPC_NUM_IO-1:0] used;
   } cspc_io_t;

   typedef struct packed {
      logic tdi;
      logic tck;
      logic tms;
   } cspc_tap_t;
endpackage

/* File: verilog/cspc_ctrl.sv */
/*
 Pin control around configuration: wait/clear/error status pin, configuration
 flags, user I/O release, global set/reset and tristate, test port gating,
 and global clock buffer pair sourcing.
 Assumes synchronous inputs on CLK_I and an external pull-up on the status pin.
*/
`timescale 1ns/1ps
`include "cspc_regs.svh"
module cspc_ctrl
   import cspc_pkg::*;
(
   input  wire logic                     CLK_I,
   input  wire logic                     RST_I,
   input  wire logic                     POWER_OK_I,
   input  wire logic                     MASTER_MODE_I,
   input  wire logic                     STATUS_PIN_I,
   output logic                          STATUS_PIN_O,
   output logic                          STATUS_PIN_OE_O,
   input  wire logic                     LOAD_DONE_I,
   input  wire logic                     DATA_ERROR_I,
   output logic                          LOAD_START_O,
   output logic                          CONFIG_ACTIVE_HIGH_FLAG_O,
   output logic                          CONFIG_ACTIVE_LOW_FLAG_O,
   input  wire cspc_io_t                 USER_IO_I,
   input  wire logic [`CSPC_NUM_IO-1:0]  IO_PAD_I,
   output logic [`CSPC_NUM_IO-1:0]       IO_PAD_O,
   output logic [`CSPC_NUM_IO-1:0]       IO_PAD_OE_O,
   output logic [`CSPC_NUM_IO-1:0]       IO_PULLUP_O,
   output logic [`CSPC_NUM_IO-1:0]       IO_IN_O,
   input  wire logic [`CSPC_NUM_IO-1:0]  GSR_SEL_I,
   input  wire logic [`CSPC_NUM_IO-1:0]  GTS_SEL_I,
   output logic                          GLOBAL_SET_RESET_NET_O,
   output logic                          GLOBAL_TRISTATE_NET_O,
   input  wire logic                     BOUNDARY_SCAN_PRIMITIVE_I,
   input  wire cspc_tap_t                TAP_PAD_I,
   output cspc_tap_t                     TAP_TO_SCAN_O,
   output cspc_tap_t                     TAP_TO_LOGIC_O,
   input  wire logic [`CSPC_NUM_GCK-1:0] GLOBAL_CLOCK_INPUT_PINS_I,
   input  wire logic [`CSPC_NUM_GCK-1:0] GCK_INT_SRC_I,
   input  wire logic [`CSPC_NUM_GCK-1:0] GCK_USE_INT_I,
   output logic [`CSPC_NUM_GCK-1:0]      GCK_LOW_SKEW_O,
   output logic [`CSPC_NUM_GCK-1:0]      GCK_EARLY_O
);

   localparam logic [`CSPC_CNT_W-1:0] WAIT_CYC = `CSPC_CNT_W'(`CSPC_WAIT_CYC);

   cspc_state_t            state_ff;
   cspc_state_t            nxt_state;
   logic [`CSPC_CNT_W-1:0] cnt_ff;
   logic [`CSPC_CNT_W-1:0] nxt_cnt;

   wire user_mode   = (state_ff == CSPC_USER);
   wire clear_done  = POWER_OK_I && (cnt_ff >= `CSPC_CLEAR_CYC);
   wire wait_needed = MASTER_MODE_I;
   wire hold_done   = (cnt_ff >= WAIT_CYC - `CSPC_CNT_W'(1));
   wire gsr_any     = |(GSR_SEL_I & IO_PAD_I);
   wire gts_any     = |(GTS_SEL_I & IO_PAD_I);
   wire tap_on      = !user_mode || BOUNDARY_SCAN_PRIMITIVE_I;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff + `CSPC_CNT_W'(1);
      unique case (state_ff)
         CSPC_CLEAR: begin
            if (!POWER_OK_I) nxt_cnt = `CSPC_CNT_RST;
            if (clear_done) begin
               nxt_state = CSPC_WAIT;
               nxt_cnt   = `CSPC_CNT_RST;
            end
         end
         CSPC_WAIT: begin
            nxt_cnt = `CSPC_CNT_RST;
            if (STATUS_PIN_I) nxt_state = wait_needed ? CSPC_HOLD : CSPC_LOAD;
         end
         CSPC_HOLD: begin
            if (!STATUS_PIN_I) begin
               nxt_state = CSPC_WAIT;
               nxt_cnt   = `CSPC_CNT_RST;
            end else if (hold_done) begin
               nxt_state = CSPC_LOAD;
            end
         end
         CSPC_LOAD: begin
            nxt_cnt = `CSPC_CNT_RST;
            if (LOAD_DONE_I && !DATA_ERROR_I) nxt_state = CSPC_USER;
         end
         CSPC_USER: begin
            nxt_cnt = `CSPC_CNT_RST;
         end
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         state_ff <= CSPC_CLEAR;
         cnt_ff   <= `CSPC_CNT_RST;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
      end
   end

   // status pin: open drain, low in clear and on data error in load
   wire err_low = (state_ff == CSPC_LOAD) && DATA_ERROR_I;
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         STATUS_PIN_O    <= 1'b0;
         STATUS_PIN_OE_O <= 1'b1;
         LOAD_START_O    <= 1'b0;
      end else begin
         STATUS_PIN_O    <= 1'b0;
         STATUS_PIN_OE_O <= (nxt_state == CSPC_CLEAR) || err_low;
         LOAD_START_O    <= (state_ff != CSPC_LOAD) && (nxt_state == CSPC_LOAD);
      end
   end

   // flags show configuration until user I/O go live, then swap levels and stay driven in user mode
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         CONFIG_ACTIVE_HIGH_FLAG_O <= 1'b1;
         CONFIG_ACTIVE_LOW_FLAG_O  <= 1'b0;
      end else begin
         CONFIG_ACTIVE_HIGH_FLAG_O <= (nxt_state != CSPC_USER);
         CONFIG_ACTIVE_LOW_FLAG_O  <= (nxt_state == CSPC_USER);
      end
   end

   // per-pin I/O block release
   genvar gi;
   generate
      for (gi = 0; gi < `CSPC_NUM_IO; gi++) begin : g_io
         wire live   = (nxt_state == CSPC_USER) && USER_IO_I.used[gi];
         wire drive  = live && USER_IO_I.oe[gi] && !gts_any;
         always_ff @(posedge CLK_I) begin
            if (RST_I) begin
               IO_PAD_O[gi]    <= 1'b0;
               IO_PAD_OE_O[gi] <= 1'b0;
               IO_PULLUP_O[gi] <= 1'b1;
               IO_IN_O[gi]     <= 1'b0;
            end else begin
               IO_PAD_O[gi]    <= USER_IO_I.out[gi];
               IO_PAD_OE_O[gi] <= drive;
               IO_PULLUP_O[gi] <= !live;
               IO_IN_O[gi]     <= IO_PAD_I[gi];
            end
         end
      end
   endgenerate

   // global nets from selected user pads; gated until user mode
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         GLOBAL_SET_RESET_NET_O <= 1'b1;
         GLOBAL_TRISTATE_NET_O  <= 1'b1;
      end else begin
         GLOBAL_SET_RESET_NET_O <= !user_mode || gsr_any;
         GLOBAL_TRISTATE_NET_O  <= !user_mode || gts_any;
      end
   end

   // test pads bypass the I/O blocks; scan side dies after load unless kept
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         TAP_TO_SCAN_O  <= '0;
         TAP_TO_LOGIC_O <= '0;
      end else begin
         TAP_TO_SCAN_O  <= tap_on ? TAP_PAD_I : '0;
         TAP_TO_LOGIC_O <= user_mode ? TAP_PAD_I : '0;
      end
   end

   // one source per buffer pair, so the two can never diverge
   generate
      for (gi = 0; gi < `CSPC_NUM_GCK; gi++) begin : g_gck
         wire src = GCK_USE_INT_I[gi] ? GCK_INT_SRC_I[gi] : GLOBAL_CLOCK_INPUT_PINS_I[gi];
         always_ff @(posedge CLK_I) begin
            if (RST_I) begin
               GCK_LOW_SKEW_O[gi] <= 1'b0;
               GCK_EARLY_O[gi]    <= 1'b0;
            end else begin
               GCK_LOW_SKEW_O[gi] <= src;
               GCK_EARLY_O[gi]    <= src;
            end
         end
      end
   endgenerate

endmodule

/* File: dv/cspc_chk_asserts.sv */
/* Checker on the cspc_ctrl ports; assumes a bind onto the controller. */
`timescale 1ns/1ps
`include "cspc_regs.svh"
module cspc_chk (
   input wire logic       CLK_I,
   input wire logic       RST_I,
   input wire logic       MASTER_MODE_I,
   input wire logic       STATUS_PIN_I,
   input wire logic       STATUS_PIN_OE_O,
   input wire logic       LOAD_DONE_I,
   input wire logic       DATA_ERROR_I,
   input wire logic       LOAD_START_O,
   input wire logic       CONFIG_ACTIVE_HIGH_FLAG_O,
   input wire logic       CONFIG_ACTIVE_LOW_FLAG_O,
   input wire logic [7:0] IO_PAD_OE_O
);
   wire         hf = CONFIG_ACTIVE_HIGH_FLAG_O;
   logic [15:0] hi_ff;
   // saturating run length of a high pin
   always_ff @(posedge CLK_I)
      if (RST_I || !STATUS_PIN_I) hi_ff <= 16'h0000;
      else if (hi_ff != 16'hFFFF) hi_ff <= hi_ff + 16'h0001;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   property p_lowf; CONFIG_ACTIVE_LOW_FLAG_O == !hf; endproperty
   a_lowf: assert property (p_lowf) else $error("flags differ");
   property p_hif; $fell(hf) |-> $past(LOAD_DONE_I); endproperty
   a_hif: assert property (p_hif) else $error("early user mode");
   property p_ldhi; LOAD_START_O |=> hf [*2]; endproperty
   a_ldhi: assert property (p_ldhi) else $error("flag low in load");
   property p_idle; hf |-> IO_PAD_OE_O == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("pad driven early");
   property p_held; !STATUS_PIN_I |=> !LOAD_START_O; endproperty
   a_held: assert property (p_held) else $error("start while held");
   property p_wait; LOAD_START_O && MASTER_MODE_I |-> hi_ff >= `CSPC_WAIT_CYC; endproperty
   a_wait: assert property (p_wait) else $error("wait too short");
   property p_err; $rose(STATUS_PIN_OE_O) |-> $past(DATA_ERROR_I) && hf; endproperty
   a_err: assert property (p_err) else $error("pin pulled wrongly");
   property p_rel; $fell(STATUS_PIN_OE_O) |-> !$past(DATA_ERROR_I); endproperty
   a_rel: assert property (p_rel) else $error("error not shown");
endmodule

/* File: dv/cspc_partner.sv */
/* Far side: wired status pin, outside hold, load done; assumes one start per load. */
`timescale 1ns/1ps
module cspc_partner (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pull_i,
   input  wire logic hold_i,
   input  wire logic start_i,
   output logic      pin_o,
   output logic      done_o
);
   logic [7:0] cnt_ff;
   // open drain: any puller beats the pull-up
   assign pin_o = !(pull_i || hold_i);
   always_ff @(posedge clk_i) begin
      if (rst_i || start_i) begin
         cnt_ff <= rst_i ? 8'h00 : 8'($urandom_range(40, 10));
         done_o <= 1'b0;
      end else if (cnt_ff != 8'h00) begin
         cnt_ff <= cnt_ff - 8'h01;
         done_o <= cnt_ff == 8'h01;
      end
   end
endmodule

/* File: dv/tb_top.sv */
/* Bench for cspc_ctrl, slave then master run; assumes cspc_partner and cspc_chk. */
`timescale 1ns/1ps
module tb_top
   import cspc_pkg::*;
;
   logic       clk = 0, rst = 1, pok = 0, mm = 0, hold = 1, err = 0, bsp = 0;
   logic       spin, soe, done, lst, hf, lf, gsn, gtn;
   logic [7:0] pad = 0, global_set_reset_net = 0, global_tristate_net = 0, gp = 0, gi = 0, gu = 0, poe, pu, gls, ge;
   cspc_io_t   uio = '0;
   cspc_tap_t  tap = '0, ts, tl;
   int         mismatches = 0, num_checks = 0, nst = 0, n;
   always #12.5 clk = ~clk;
   always @(posedge clk) if (lst === 1'b1) nst++;
   cspc_ctrl dut_u (.CLK_I(clk), .RST_I(rst), .POWER_OK_I(pok), .MASTER_MODE_I(mm), .STATUS_PIN_I(spin),
      .STATUS_PIN_O(), .STATUS_PIN_OE_O(soe), .LOAD_DONE_I(done), .DATA_ERROR_I(err), .LOAD_START_O(lst),
      .CONFIG_ACTIVE_HIGH_FLAG_O(hf), .CONFIG_ACTIVE_LOW_FLAG_O(lf), .USER_IO_I(uio), .IO_PAD_I(pad),
      .IO_PAD_O(), .IO_PAD_OE_O(poe), .IO_PULLUP_O(pu), .IO_IN_O(), .GSR_SEL_I(global_set_reset_net), .GTS_SEL_I(global_tristate_net),
      .GLOBAL_SET_RESET_NET_O(gsn), .GLOBAL_TRISTATE_NET_O(gtn), .BOUNDARY_SCAN_PRIMITIVE_I(bsp),
      .TAP_PAD_I(tap), .TAP_TO_SCAN_O(ts), .TAP_TO_LOGIC_O(tl), .GLOBAL_CLOCK_INPUT_PINS_I(gp),
      .GCK_INT_SRC_I(gi), .GCK_USE_INT_I(gu), .GCK_LOW_SKEW_O(gls), .GCK_EARLY_O(ge));
   cspc_partner prt_u (.clk_i(clk), .rst_i(rst), .pull_i(soe), .hold_i(hold), .start_i(lst),
      .pin_o(spin), .done_o(done));
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input logic ok);
      num_checks++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("BAD %0t model differs", $time);
      end
   endtask
   task tmo(input logic ok);
      if (!ok) begin
         mismatches++;
         finish_test;
      end
   endtask
   task cyc(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask
   initial begin
      void'($urandom(32'hF657));
      for (int m = 0; m < 2; m++) begin
         {rst, hold, pok, global_set_reset_net, global_tristate_net, mm, bsp} = {3'b110, 16'h0000, m[0], m[0]};
         {pad, gp, gi, gu, uio, tap} = 59'({$urandom, $urandom});
         cyc(2);
         {rst, nst} = 33'h0;
         cyc(10);
         chk({soe, hf, lf, poe, pu} === {3'b110, 16'h00FF});
         chk(gls === (gi & gu | gp & ~gu) && ge === gls);
         pok = 1;
         for (n = 0; n < 200 && soe !== 0; n++) cyc(1);
         tmo(n < 200);
         chk(n >= 63 && spin === 0);
         cyc(1500);
         // master: a short release must restart the wait
         if (m) begin
            hold = 0;
            cyc(600);
            hold = 1;
            cyc(5);
         end
         chk({nst, hf, poe} === {32'h0, 9'h100});
         hold = 0;
         for (n = 0; n < 13000 && lst !== 1; n++) cyc(1);
         tmo(n < 13000);
         chk(m ? n >= 1199 && n <= 12000 : n < 1200);
         err = 1;
         cyc(2);
         chk({soe, spin, hf} === 3'b101);
         err = 0;
         for (n = 0; n < 100 && hf !== 0; n++) cyc(1);
         tmo(n < 100);
         cyc(1);
         chk({lf, soe, poe, pu & ~uio.used} === {2'b10, uio.used & uio.oe, ~uio.used});
         {pad[0], global_tristate_net} = 9'h101;
         cyc(2);
         chk({gtn, gsn, poe} === 10'h200);
         {global_tristate_net, global_set_reset_net} = 16'h0001;
         cyc(2);
         chk({gsn, gtn, poe} === {2'b10, uio.used & uio.oe});
         chk({tl, ts} === {tap, m ? tap : 3'b000});
      end
      finish_test;
   end
endmodule
bind cspc_ctrl cspc_chk chk_u (.*);
